// ===== rtl/swm_link_map.vh
`ifndef SWM_LINK_MAP_VH
`define SWM_LINK_MAP_VH
// Clock rate in MHz.
`define SWM_CLK_MHZ          100
// Timing figures in microseconds, regular speed.
`define SWM_RST_LOW_US       480
`define SWM_PRES_WIN_US      70
`define SWM_RST_TAIL_US      410
`define SWM_SLOT_US          70
`define SWM_W0_LOW_US        60
`define SWM_W1_LOW_US        6
`define SWM_RD_LOW_US        6
`define SWM_RD_SAMP_US       13
`define SWM_REC_US           5
// Timing figures in microseconds, high speed.
`define SWM_HS_RST_LOW_US    70
`define SWM_HS_PRES_WIN_US   9
`define SWM_HS_RST_TAIL_US   40
`define SWM_HS_SLOT_US       10
`define SWM_HS_W0_LOW_US     8
`define SWM_HS_W1_LOW_US     1
`define SWM_HS_RD_LOW_US     1
`define SWM_HS_RD_SAMP_US    2
`define SWM_HS_REC_US        2
// Identity-selection command codes.
`define SWM_CMD_READ_ID      8'h33
`define SWM_CMD_SELECT       8'h55
`define SWM_CMD_SKIP         8'hCC
`define SWM_CMD_SEARCH       8'hF0
`define SWM_CMD_HS_SKIP      8'h3C
`define SWM_CMD_HS_SELECT    8'h69
// Host operation codes on OP.
`define SWM_OP_RESET         3'h0
`define SWM_OP_WRITE_BIT     3'h1
`define SWM_OP_READ_BIT      3'h2
`define SWM_OP_WRITE_BYTE    3'h3
`define SWM_OP_READ_BYTE     3'h4
`define SWM_OP_TRIPLET       3'h5
`define SWM_OP_SET_SPEED     3'h6
`endif

// ===== rtl/swm_master.v
`timescale 1ns/100ps
`include "swm_link_map.vh"
module swm_master (
  input  wire       CLK,
  input  wire       RST,
  input  wire       REQ,
  input  wire [2:0] OP,
  input  wire [7:0] WDATA,
  input  wire       LINE_IN,
  output reg        LINE_OUT,
  output reg        LINE_OE_N,
  output reg        BUSY,
  output reg        DONE,
  output reg  [7:0] RDATA,
  output reg        HIGH_SPEED
);
  localparam [1:0] K_RESET = 2'd0;
  localparam [1:0] K_WRITE = 2'd1;
  localparam [1:0] K_READ  = 2'd2;
  localparam [3:0] S_IDLE  = 4'b0001;
  localparam [3:0] S_ISSUE = 4'b0010;
  localparam [3:0] S_WAIT  = 4'b0100;
  localparam [3:0] S_END   = 4'b1000;
  reg [3:0] state_r;
  reg [2:0] op_r;
  reg [7:0] sh_r;
  reg [3:0] bits_r;
  reg [1:0] phase_r;
  reg       tb0_r;
  reg       tb1_r;
  reg       go_r;
  reg [1:0] kind_r;
  reg       wb_r;
  reg       hs_r;
  wire      slot_oe_n;
  wire      slot_done;
  wire      slot_bit;
  swm_slot u_slot (
    .clk       (CLK),
    .rst       (RST),
    .start     (go_r),
    .kind      (kind_r),
    .hs        (hs_r),
    .wbit      (wb_r),
    .line_in   (LINE_IN),
    .line_oe_n (slot_oe_n),
    .done      (slot_done),
    .rbit      (slot_bit)
  );
  // The output value is always low; only the enable moves, so the pin is open drain.
  always @(posedge CLK) begin
    if (RST) begin
      LINE_OUT  <= 1'b0;
      LINE_OE_N <= 1'b1;
    end else begin
      LINE_OUT  <= 1'b0;
      LINE_OE_N <= slot_oe_n;
    end
  end
  always @(posedge CLK) begin
    if (RST) begin
      state_r    <= S_IDLE;
      op_r       <= 3'h0;
      sh_r       <= 8'h00;
      bits_r     <= 4'h0;
      phase_r    <= 2'd0;
      tb0_r      <= 1'b0;
      tb1_r      <= 1'b0;
      go_r       <= 1'b0;
      kind_r     <= K_RESET;
      wb_r       <= 1'b0;
      hs_r       <= 1'b0;
      BUSY       <= 1'b0;
      DONE       <= 1'b0;
      RDATA      <= 8'h00;
      HIGH_SPEED <= 1'b0;
    end else begin
      DONE <= 1'b0;
      go_r <= 1'b0;
      case (state_r)
        S_IDLE: begin
          // Requests are only taken here, so a second one while busy is dropped.
          if (REQ) begin
            op_r    <= OP;
            sh_r    <= WDATA;
            phase_r <= 2'd0;
            BUSY    <= 1'b1;
            // The host does not snoop the codes it sends; software switches speed afterwards.
            if (OP == `SWM_OP_SET_SPEED) begin
              hs_r       <= WDATA[0];
              HIGH_SPEED <= WDATA[0];
              state_r    <= S_END;
            end else begin
              if (OP == `SWM_OP_WRITE_BYTE || OP == `SWM_OP_READ_BYTE)
                bits_r <= 4'h8;
              else
                bits_r <= 4'h1;
              state_r <= S_ISSUE;
            end
          end
        end
        S_ISSUE: begin
          go_r <= 1'b1;
          case (op_r)
            `SWM_OP_RESET:      kind_r <= K_RESET;
            `SWM_OP_WRITE_BIT,
            `SWM_OP_WRITE_BYTE: begin
              kind_r <= K_WRITE;
              wb_r   <= sh_r[0];
            end
            `SWM_OP_TRIPLET: begin
              // Third slot writes the chosen direction.
              kind_r <= (phase_r == 2'd2) ? K_WRITE : K_READ;
              wb_r   <= (tb0_r ^ tb1_r) ? tb0_r : sh_r[0];
            end
            default: kind_r <= K_READ;
          endcase
          state_r <= S_WAIT;
        end
        S_WAIT: begin
          if (slot_done) begin
            if (op_r == `SWM_OP_TRIPLET) begin
              if (phase_r == 2'd0)
                tb0_r <= slot_bit;
              if (phase_r == 2'd1)
                tb1_r <= slot_bit;
              if (phase_r == 2'd2) begin
                RDATA   <= {5'h00, wb_r, tb1_r, tb0_r};
                state_r <= S_END;
              end else begin
                phase_r <= phase_r + 2'd1;
                state_r <= S_ISSUE;
              end
            end else begin
              sh_r   <= {slot_bit, sh_r[7:1]};
              bits_r <= bits_r - 4'h1;
              if (bits_r == 4'h1) begin
                if (op_r == `SWM_OP_RESET)
                  RDATA <= {7'h00, slot_bit};
                else if (op_r == `SWM_OP_READ_BIT)
                  RDATA <= {7'h00, slot_bit};
                // With several slaves answering, this byte is the AND of their bits.
                else
                  RDATA <= {slot_bit, sh_r[7:1]};
                // A regular-speed reset drops every slave back to regular speed.
                if (op_r == `SWM_OP_RESET && !hs_r)
                  HIGH_SPEED <= 1'b0;
                state_r <= S_END;
              end else begin
                state_r <= S_ISSUE;
              end
            end
          end
        end
        S_END: begin
          BUSY    <= 1'b0;
          DONE    <= 1'b1;
          state_r <= S_IDLE;
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end
endmodule // swm_master

// ===== rtl/swm_slot.v
`timescale 1ns/100ps
`include "swm_link_map.vh"
// Generates one reset/presence sequence or one bit slot on the open-drain line.
module swm_slot (
  input  wire       clk,
  input  wire       rst,
  input  wire       start,
  input  wire [1:0] kind,
  input  wire       hs,
  input  wire       wbit,
  input  wire       line_in,
  output reg        line_oe_n,
  output reg        done,
  output reg        rbit
);
  // A regular reset spans 96000 cycles, so every count here needs 17 bits.
  function [16:0] cyc;
    input integer us;
    reg [31:0] prod;
    begin
      prod = us * `SWM_CLK_MHZ;
      cyc  = prod[16:0];
    end
  endfunction
  localparam [1:0] K_RESET = 2'd0;
  localparam [1:0] K_WRITE = 2'd1;
  localparam [1:0] K_READ  = 2'd2;
  localparam [2:0] S_IDLE = 3'b001;
  localparam [2:0] S_LOW  = 3'b010;
  localparam [2:0] S_HIGH = 3'b100;
  reg [2:0]  state_r;
  reg [16:0] cnt_r;
  reg [1:0]  kind_r;
  reg        hs_r;
  reg        pres_seen_r;
  wire [16:0] low_len;
  wire [16:0] total_len;
  wire [16:0] samp_at;
  assign low_len = (kind_r == K_RESET) ? (hs_r ? cyc(`SWM_HS_RST_LOW_US) : cyc(`SWM_RST_LOW_US)) :
                   (kind_r == K_READ)  ? (hs_r ? cyc(`SWM_HS_RD_LOW_US) : cyc(`SWM_RD_LOW_US)) :
                   (wbit ? (hs_r ? cyc(`SWM_HS_W1_LOW_US) : cyc(`SWM_W1_LOW_US))
                         : (hs_r ? cyc(`SWM_HS_W0_LOW_US) : cyc(`SWM_W0_LOW_US)));
  assign total_len = (kind_r == K_RESET) ?
                     (hs_r ? cyc(`SWM_HS_RST_LOW_US + `SWM_HS_PRES_WIN_US + `SWM_HS_RST_TAIL_US)
                           : cyc(`SWM_RST_LOW_US + `SWM_PRES_WIN_US + `SWM_RST_TAIL_US)) :
                     (hs_r ? cyc(`SWM_HS_SLOT_US + `SWM_HS_REC_US)
                           : cyc(`SWM_SLOT_US + `SWM_REC_US));
  assign samp_at = (kind_r == K_RESET) ?
                   (hs_r ? cyc(`SWM_HS_RST_LOW_US + `SWM_HS_PRES_WIN_US)
                         : cyc(`SWM_RST_LOW_US + `SWM_PRES_WIN_US)) :
                   (hs_r ? cyc(`SWM_HS_RD_SAMP_US) : cyc(`SWM_RD_SAMP_US));
  always @(posedge clk) begin
    if (rst) begin
      state_r     <= S_IDLE;
      cnt_r       <= 17'h0_0000;
      kind_r      <= K_RESET;
      hs_r        <= 1'b0;
      pres_seen_r <= 1'b0;
      line_oe_n   <= 1'b1;
      done        <= 1'b0;
      rbit        <= 1'b0;
    end else begin
      done <= 1'b0;
      case (state_r)
        S_IDLE: begin
          if (start) begin
            kind_r      <= kind;
            hs_r        <= hs;
            cnt_r       <= 17'h0_0000;
            pres_seen_r <= 1'b0;
            line_oe_n   <= 1'b0;
            state_r     <= S_LOW;
          end
        end
        S_LOW: begin
          cnt_r <= cnt_r + 17'h0_0001;
          if (cnt_r + 17'h0_0001 >= low_len) begin
            line_oe_n <= 1'b1;
            state_r   <= S_HIGH;
          end
        end
        S_HIGH: begin
          cnt_r <= cnt_r + 17'h0_0001;
          // Presence is any low seen in the window after release.
          if (kind_r == K_RESET && cnt_r > low_len + 17'h0_0010 && cnt_r < samp_at && !line_in)
            pres_seen_r <= 1'b1;
          if (kind_r != K_RESET && cnt_r == samp_at)
            rbit <= line_in;
          if (cnt_r + 17'h0_0001 >= total_len) begin
            if (kind_r == K_RESET)
              rbit <= pres_seen_r;
            done    <= 1'b1;
            state_r <= S_IDLE;
          end
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end
endmodule // swm_slot

// ===== tb/swm_dev_model.sv
`timescale 1ns/100ps
module swm_dev_model #(
  parameter logic [63:0] ID = 64'h0123_4567_89AB_CDA6  // Arbitrary identity.
) (
  input  wire  line,
  output logic pull
);
  logic       hs = 1'b0;
  logic       b;
  logic       rd;
  logic       smp;
  logic [7:0] sr = 8'h00;
  logic [7:0] cmd_got = 8'h00;
  int         st = 0;
  int         n = 0;
  int         ph = 0;
  realtime    t0;
  initial pull = 1'b0;
  always @(negedge line) begin
    t0 = $realtime;
    rd = (st == 2 && ph != 2) || st == 5;
    b = ph[0] ? ~ID[n] : ID[n];
    if (rd && !b) pull = 1'b1;
    #(hs ? 3000 : (rd ? 15000 : 30000));
    pull = 1'b0;
    smp = line;
    if (st == 1) begin
      sr = {smp, sr[7:1]};
      n++;
      if (n == 8) begin
        cmd_got = sr;
        n = 0;
        st = (sr == 8'hF0) ? 2 : 4;
        if (sr == 8'h33) st = 5;
        if (sr == 8'h55 || sr == 8'h69) st = 6;
        if (sr == 8'h3C) hs = 1'b1;
      end
    end else if (st == 2) begin
      if (ph == 2 && smp !== ID[n]) st = 3;
      if (ph == 2) n++;
      ph = (ph == 2) ? 0 : ph + 1;
    end else if (st == 5) begin
      n++;
    end else if (st == 6) begin
      // A mismatch drops out but leaves the speed as it was.
      if (smp !== ID[n]) st = 3;
      n++;
      if (n == 64 && st == 6) begin
        st = 4;
        if (cmd_got == 8'h69) hs = 1'b1;
      end
    end
    // A released line is pulled up, so waiting on the level cannot miss a short low.
    wait (line === 1'b1);
    if ($realtime - t0 >= 480000.0) hs = 1'b0;
    if ($realtime - t0 >= (hs ? 48000.0 : 480000.0)) begin
      st = 1;
      n = 0;
      ph = 0;
      #(hs ? 3000 : 20000);
      pull = 1'b1;
      #(hs ? 12000 : 100000);
      pull = 1'b0;
    end
  end
endmodule // swm_dev_model

// ===== tb/swm_master_bench.sv
`timescale 1ns/100ps
module swm_master_bench;
  localparam logic [63:0] DEV_ID = 64'h0123_4567_89AB_CDA6;
  logic       CLK = 1'b0;
  logic       RST = 1'b1;
  logic       REQ = 1'b0;
  logic [2:0] OP = 3'h0;
  logic [7:0] WDATA = 8'h00;
  wire        LINE_OUT, LINE_OE_N, BUSY, DONE, HIGH_SPEED, dev_pull;
  wire  [7:0] RDATA;
  wire        line_w = ((LINE_OE_N === 1'b0 && LINE_OUT === 1'b0) || dev_pull === 1'b1) ? 1'b0 : 1'b1;
  int         fails = 0;
  int         n_checks = 0;
  int         cyc = 0;
  logic [7:0] exp_q[$];
  always #5 CLK = ~CLK;
  swm_master i_dut (.CLK(CLK), .RST(RST), .REQ(REQ), .OP(OP), .WDATA(WDATA), .LINE_IN(line_w),
    .LINE_OUT(LINE_OUT), .LINE_OE_N(LINE_OE_N), .BUSY(BUSY), .DONE(DONE), .RDATA(RDATA),
    .HIGH_SPEED(HIGH_SPEED));
  swm_dev_model #(.ID(DEV_ID)) i_dev (.line(line_w), .pull(dev_pull));
  task automatic end_sim;
    $display("Checks %0d, mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      $display("Error at %0t: %s got %h want %h", $time, m, got, exp);
      fails++;
    end
  endtask
  task automatic op(input logic [2:0] o, input logic [7:0] d);
    int k;
    @(posedge CLK);
    #1;
    REQ = 1'b1;
    OP = o;
    WDATA = d;
    @(posedge CLK);
    #1;
    REQ = 1'b0;
    k = 0;
    while (DONE !== 1'b1 && k < 120000) begin
      @(posedge CLK);
      #1;
      k++;
    end
    if (k >= 120000) begin
      chk(8'h00, 8'h01, "no done");
      end_sim();
    end
  endtask
  // The one regular reset and regular byte take about 156000 cycles; the rest about 85000.
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 300000) begin
      chk(8'h00, 8'h01, "run too long");
      end_sim();
    end
  end
  initial begin
    int k;
    void'($urandom(16306));
    repeat (16) @(posedge CLK);
    #1;
    RST = 1'b0;
    chk({4'h0, BUSY, DONE, HIGH_SPEED, LINE_OE_N}, 8'h01, "idle");
    op(3'h0, 8'h00);
    chk({7'h00, RDATA[0]}, 8'h01, "presence");
    $display("Test regular reset done");
    op(3'h3, 8'h3C);
    chk(i_dev.cmd_got, 8'h3C, "code bits");
    chk({7'h00, i_dev.hs}, 8'h01, "device speed");
    op(3'h6, 8'h01);
    chk({7'h00, HIGH_SPEED}, 8'h01, "host speed");
    op(3'h0, 8'h00);
    chk({6'h00, HIGH_SPEED, RDATA[0]}, 8'h03, "fast presence");
    $display("Test fast mode done");
    op(3'h3, 8'hF0);
    chk(i_dev.cmd_got, 8'hF0, "search code");
    for (k = 0; k < 5; k++) exp_q.push_back({5'h00, DEV_ID[k], ~DEV_ID[k], DEV_ID[k]});
    for (k = 0; k < 5; k++) begin
      op(3'h5, 8'($urandom));
      chk(RDATA, exp_q.pop_front(), "triplet");
    end
    op(3'h2, 8'h00);
    chk({7'h00, RDATA[0]}, {7'h00, DEV_ID[5]}, "read bit");
    op(3'h2, 8'h00);
    chk({7'h00, RDATA[0]}, {7'h00, ~DEV_ID[5]}, "read complement");
    op(3'h1, {7'h00, ~DEV_ID[5]});
    op(3'h2, 8'h00);
    chk({7'h00, RDATA[0]}, 8'h01, "dropped device silent");
    $display("Test search done");
    op(3'h0, 8'h00);
    chk({7'h00, RDATA[0]}, 8'h01, "second fast presence");
    op(3'h3, 8'h33);
    chk(i_dev.cmd_got, 8'h33, "read id code");
    op(3'h4, 8'h00);
    chk(RDATA, DEV_ID[7:0], "identity byte 0");
    op(3'h4, 8'h00);
    chk(RDATA, DEV_ID[15:8], "identity byte 1");
    op(3'h6, 8'h00);
    chk({7'h00, HIGH_SPEED}, 8'h00, "host speed back");
    $display("Test read identity done");
    end_sim();
  end
endmodule // swm_master_bench

// ===== tb/swm_master_props.sv
`timescale 1ns/100ps
module swm_master_props (
  input logic       CLK,
  input logic       RST,
  input logic       REQ,
  input logic [2:0] OP,
  input logic [7:0] WDATA,
  input logic       LINE_IN,
  input logic       LINE_OUT,
  input logic       LINE_OE_N,
  input logic       BUSY,
  input logic       DONE,
  input logic [7:0] RDATA,
  input logic       HIGH_SPEED
);
  logic [16:0] low_r;
  logic [2:0]  op_r;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  // Pulse lengths are judged when the line is let go, so the stretch is counted here.
  always_ff @(posedge CLK) begin
    low_r <= (RST || LINE_OE_N) ? 17'h0_0000 : low_r + 17'h0_0001;
    op_r <= RST ? 3'h0 : (REQ && !BUSY) ? OP : op_r;
  end
  sequence s_take;
    REQ && !BUSY;
  endsequence
  sequence s_rel;
    $rose(LINE_OE_N);
  endsequence
  a_drive_low_only: assert property (!LINE_OE_N |-> !LINE_OUT)
    else $error("line driven high");
  a_idle_released: assert property (!BUSY |-> LINE_OE_N)
    else $error("line held while idle");
  a_take_busy: assert property (s_take |=> BUSY)
    else $error("request not taken");
  a_busy_until_done: assert property (BUSY && !DONE |=> BUSY || DONE)
    else $error("busy dropped early");
  a_done_pulse: assert property (DONE |=> !DONE)
    else $error("done longer than one cycle");
  a_slot_start: assert property (s_take ##0 OP != 3'h6 |-> ##[1:4] !LINE_OE_N)
    else $error("slot not started by falling edge");
  a_reset_regular: assert property (s_rel ##0 (op_r == 3'h0 && !HIGH_SPEED) |-> low_r >= 17'h0_BB80)
    else $error("regular reset too short");
  a_reset_fast: assert property (s_rel ##0 (op_r == 3'h0 && HIGH_SPEED) |->
    low_r >= 17'h0_12C0 && low_r <= 17'h0_1F40)
    else $error("fast reset length wrong");
  a_slot_len: assert property (s_rel ##0 op_r != 3'h0 |->
    low_r <= (HIGH_SPEED ? 17'h0_0640 : 17'h0_2EE0))
    else $error("slot low too long");
  a_speed_set: assert property (s_take ##0 (OP == 3'h6 && WDATA[0]) |-> ##[1:3] (DONE && HIGH_SPEED))
    else $error("speed not set");
  a_speed_cause: assert property ($changed(HIGH_SPEED) |-> op_r == 3'h6)
    else $error("speed changed without cause");
endmodule // swm_master_props
bind swm_master swm_master_props i_props (
  .CLK(CLK), .RST(RST), .REQ(REQ), .OP(OP), .WDATA(WDATA), .LINE_IN(LINE_IN),
  .LINE_OUT(LINE_OUT), .LINE_OE_N(LINE_OE_N), .BUSY(BUSY), .DONE(DONE),
  .RDATA(RDATA), .HIGH_SPEED(HIGH_SPEED));
